// *** hw/sfpi_core.sv ***
// sfpi_core: pin-level serial interface of a serial flash device
// assumes: host drives sck and the select; the flash core supplies read
// bytes, phase and mode, and takes received bytes from the fifo
`timescale 1ns/1ps
`default_nettype none
module sfpi_core #(
  parameter int unsigned DEPTH = sfpi_pkg::FIFO_DEPTH,
  parameter int unsigned BLK_W = sfpi_pkg::BLK_W
) (
  input  wire logic                  clock_i,
  input  wire logic                  rst_n_i,
  // pins
  input  wire logic                  sck_i,
  input  wire logic                  cs_n_i,
  input  wire logic [3:0]            lane_i,
  output logic      [3:0]            lane_o,
  output logic      [3:0]            lane_oe_o,
  // flash core side
  input  wire logic                  quad_cfg_i,
  input  wire logic [1:0]            mode_i,
  input  wire logic                  out_phase_i,
  input  wire logic                  busy_i,
  input  wire logic [7:0]            tx_data_i,
  input  wire logic                  tx_valid_i,
  output logic                       tx_ready_o,
  output logic      [7:0]            rx_data_o,
  output logic                       rx_valid_o,
  input  wire logic                  rx_ready_i,
  input  wire logic [2:0]            protect_range_bits_i,
  input  wire logic                  wr_req_i,
  input  wire logic [BLK_W-1:0]      wr_block_i,
  output logic                       wr_grant_o,
  output logic                       wr_reject_o,
  output logic                       standby_o,
  output logic                       selected_o,
  output logic                       rx_overflow_o,
  output logic                       tx_underrun_o
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] step_of(input logic [1:0] m);
    case (m)
      sfpi_pkg::SFPI_DUAL: step_of = sfpi_pkg::STEP_TWO;
      sfpi_pkg::SFPI_QUAD: step_of = sfpi_pkg::STEP_FOUR;
      default:             step_of = sfpi_pkg::STEP_ONE;
    endcase
  endfunction

  function automatic logic [7:0] shift_in(input logic [1:0] m,
                                          input logic [7:0] sh,
                                          input logic [3:0] ln);
    case (m)
      sfpi_pkg::SFPI_DUAL: shift_in = {sh[5:0], ln[1:0]};
      sfpi_pkg::SFPI_QUAD: shift_in = {sh[3:0], ln[3:0]};
      default:             shift_in = {sh[6:0], ln[0]};
    endcase
  endfunction

  function automatic logic [3:0] lanes_of(input logic [1:0] m,
                                          input logic [7:0] b);
    case (m)
      sfpi_pkg::SFPI_DUAL: lanes_of = {2'b00, b[7:6]};
      sfpi_pkg::SFPI_QUAD: lanes_of = b[7:4];
      default:             lanes_of = {2'b00, b[7], 1'b0};
    endcase
  endfunction

  function automatic logic [3:0] oe_of(input logic [1:0] m);
    case (m)
      sfpi_pkg::SFPI_DUAL: oe_of = sfpi_pkg::OE_DUAL;
      sfpi_pkg::SFPI_QUAD: oe_of = sfpi_pkg::OE_QUAD;
      default:             oe_of = sfpi_pkg::OE_SINGLE;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [5:0] sy1_q;
  logic [5:0] sy2_q;
  logic       sck_old_q;
  logic       cs_old_q;

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      // select resets low as well: a select already held low at reset
      // must not look like a falling edge and arm the link
      sy1_q     <= 6'h00;
      sy2_q     <= 6'h00;
      sck_old_q <= 1'b0;
      cs_old_q  <= 1'b0;
    end
    else
    begin
      sy1_q     <= {lane_i, cs_n_i, sck_i};
      sy2_q     <= sy1_q;
      sck_old_q <= sy2_q[0];
      cs_old_q  <= sy2_q[1];
    end
  end

  wire       sck_s   = sy2_q[0];
  wire       cs_s    = sy2_q[1];
  wire [3:0] lane_s  = sy2_q[5:2];
  // either idle level of sck works: only edges are used
  wire       sck_up  = sck_s && !sck_old_q;
  wire       sck_dn  = !sck_s && sck_old_q;
  wire       cs_fall = !cs_s && cs_old_q;

  // four-lane setting turns the pause and protect functions off
  wire       pause_n = quad_cfg_i || lane_s[3];
  wire       prot_n  = quad_cfg_i || lane_s[2];

  // ----------------------------------------------------------------
  // link state
  // ----------------------------------------------------------------
  sfpi_pkg::sfpi_state_t st_q;
  sfpi_pkg::sfpi_state_t st_d;

  always_comb
  begin
    st_d = st_q;
    case (st_q)
      sfpi_pkg::SFPI_UNARMED:
        if (cs_fall) st_d = sfpi_pkg::SFPI_ACTIVE;
      sfpi_pkg::SFPI_DESEL:
        if (cs_fall) st_d = sfpi_pkg::SFPI_ACTIVE;
      sfpi_pkg::SFPI_ACTIVE:
        if (cs_s) st_d = sfpi_pkg::SFPI_DESEL;
        else if (!pause_n) st_d = sfpi_pkg::SFPI_PAUSED;
      sfpi_pkg::SFPI_PAUSED:
        if (cs_s) st_d = sfpi_pkg::SFPI_DESEL;
        else if (pause_n) st_d = sfpi_pkg::SFPI_ACTIVE;
      default:
        st_d = sfpi_pkg::SFPI_UNARMED;
    endcase
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      st_q <= sfpi_pkg::SFPI_UNARMED;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // edges count only in the active state; a paused transfer keeps
  // every shift register untouched so release picks up mid-byte
  wire active  = (st_q == sfpi_pkg::SFPI_ACTIVE) && !cs_s && pause_n;
  wire desel   = cs_s;
  wire [3:0] step = step_of(mode_i);

  // ----------------------------------------------------------------
  // receive shifter
  // ----------------------------------------------------------------
  sfpi_stream_if #(.WIDTH(sfpi_pkg::BYTE_BITS)) rx_fill ();
  sfpi_stream_if #(.WIDTH(sfpi_pkg::BYTE_BITS)) rx_drain ();

  logic [7:0] rsh_q;
  logic [3:0] rcnt_q;
  logic       push_q;
  logic [7:0] pdat_q;
  logic       ovf_q;

  wire        take_bit = active && sck_up && !out_phase_i;
  wire [3:0]  rcnt_nx  = rcnt_q + step;
  wire [7:0]  rsh_nx   = shift_in(mode_i, rsh_q, lane_s);
  wire        byte_end = take_bit && (rcnt_nx == sfpi_pkg::CNT_BYTE);

  assign rx_fill.valid = push_q;
  assign rx_fill.data  = pdat_q;

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i || desel)
    begin
      rsh_q  <= '0;
      rcnt_q <= '0;
    end
    else if (take_bit)
    begin
      rsh_q  <= rsh_nx;
      rcnt_q <= byte_end ? '0 : rcnt_nx;
    end
  end

  // a host cannot be stalled, so a byte meeting a full fifo is lost
  // and the sticky overflow flag tells the core
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      push_q <= 1'b0;
      pdat_q <= '0;
      ovf_q  <= 1'b0;
    end
    else
    begin
      push_q <= byte_end;
      pdat_q <= byte_end ? rsh_nx : pdat_q;
      ovf_q  <= ovf_q || (push_q && !rx_fill.ready);
    end
  end

  sfpi_fifo #(
    .WIDTH (sfpi_pkg::BYTE_BITS),
    .DEPTH (DEPTH)
  ) u_rx_fifo (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .wr      (rx_fill),
    .rd      (rx_drain)
  );

  assign rx_drain.ready = rx_ready_i;
  assign rx_data_o      = rx_drain.data;
  assign rx_valid_o     = rx_drain.valid;

  // ----------------------------------------------------------------
  // transmit holding register and shifter
  // ----------------------------------------------------------------
  logic [7:0] hold_q;
  logic       hfull_q;
  logic [7:0] tsh_q;
  logic [3:0] tcnt_q;
  logic       drive_q;
  logic [3:0] lane_q;
  logic [3:0] oe_q;
  logic       unr_q;

  wire        shift_out = active && sck_dn && out_phase_i;
  wire        load      = shift_out && (tcnt_q == '0);
  wire [7:0]  cur       = !load ? tsh_q : (hfull_q ? hold_q : sfpi_pkg::IDLE_BYTE);
  wire [3:0]  tcnt_nx   = tcnt_q + step;
  wire        hold_in   = tx_valid_i && !hfull_q;

  assign tx_ready_o = !hfull_q;

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      hold_q  <= '0;
      hfull_q <= 1'b0;
      unr_q   <= 1'b0;
    end
    else
    begin
      hold_q  <= hold_in ? tx_data_i : hold_q;
      hfull_q <= hold_in || (hfull_q && !(load && !desel));
      unr_q   <= unr_q || (load && !hfull_q);
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i || desel || !out_phase_i)
    begin
      tsh_q  <= '0;
      tcnt_q <= '0;
    end
    else if (shift_out)
    begin
      tsh_q  <= cur << step;
      tcnt_q <= (tcnt_nx == sfpi_pkg::CNT_BYTE) ? '0 : tcnt_nx;
    end
  end

  // lanes are only driven from the first falling edge of an output
  // phase, so the half clock before it leaves the bus released
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i || desel || !out_phase_i)
    begin
      drive_q <= 1'b0;
      lane_q  <= '0;
    end
    else if (shift_out)
    begin
      drive_q <= 1'b1;
      lane_q  <= lanes_of(mode_i, cur);
    end
  end

  // enables follow drive state; pause and deselect float everything
  wire [3:0] oe_d = (drive_q && active && !desel) ? oe_of(mode_i) : '0;

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      oe_q <= '0;
    end
    else
    begin
      oe_q <= oe_d;
    end
  end

  assign lane_o        = lane_q;
  assign lane_oe_o     = oe_q;
  assign rx_overflow_o = ovf_q;
  assign tx_underrun_o = unr_q;

  // ----------------------------------------------------------------
  // write protection and standby
  // ----------------------------------------------------------------
  // range n protects the top 2^(n-1) blocks, all blocks at the top code
  function automatic logic in_range(input logic [2:0]       bp,
                                    input logic [BLK_W-1:0] blk);
    logic [BLK_W:0] lim;
    lim = '0;
    if (bp == sfpi_pkg::PROT_NONE)
      in_range = 1'b0;
    else if (bp == sfpi_pkg::PROT_ALL)
      in_range = 1'b1;
    else
    begin
      lim      = (BLK_W+1)'(1) << (BLK_W+1)'(bp - 3'h1);
      in_range = ({1'b0, blk} >= ((BLK_W+1)'(1) << BLK_W) - lim);
    end
  endfunction

  wire hit = in_range(protect_range_bits_i, wr_block_i);
  logic gr_q;
  logic rj_q;
  logic sb_q;
  logic sl_q;

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      gr_q <= 1'b0;
      rj_q <= 1'b0;
      sb_q <= 1'b0;
      sl_q <= 1'b0;
    end
    else
    begin
      gr_q <= wr_req_i && !(hit && !prot_n);
      rj_q <= wr_req_i && hit && !prot_n;
      sb_q <= cs_s && !busy_i;
      sl_q <= (st_d == sfpi_pkg::SFPI_ACTIVE) || (st_d == sfpi_pkg::SFPI_PAUSED);
    end
  end

  assign wr_grant_o  = gr_q;
  assign wr_reject_o = rj_q;
  assign standby_o   = sb_q;
  assign selected_o  = sl_q;

endmodule
`default_nettype wire

// *** hw/sfpi_pkg.sv ***
// sfpi_pkg: shared constants and types of the serial flash pin interface
// assumes: included before the interface and the design modules
package sfpi_pkg;

  // ----------------------------------------------------------------
  // lanes and bytes
  // ----------------------------------------------------------------
  localparam int unsigned LANES      = 4;
  localparam int unsigned BYTE_BITS  = 8;
  localparam int unsigned CNT_W      = 4;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned BLK_W      = 6;
  localparam int unsigned PROT_W     = 3;

  localparam logic [CNT_W-1:0]     CNT_BYTE   = 4'h8;
  localparam logic [CNT_W-1:0]     STEP_ONE   = 4'h1;
  localparam logic [CNT_W-1:0]     STEP_TWO   = 4'h2;
  localparam logic [CNT_W-1:0]     STEP_FOUR  = 4'h4;
  localparam logic [BYTE_BITS-1:0] IDLE_BYTE  = 8'hff;
  localparam logic [LANES-1:0]     OE_SINGLE  = 4'h2;
  localparam logic [LANES-1:0]     OE_DUAL    = 4'h3;
  localparam logic [LANES-1:0]     OE_QUAD    = 4'hf;
  localparam logic [PROT_W-1:0]    PROT_NONE  = 3'h0;
  localparam logic [PROT_W-1:0]    PROT_ALL   = 3'h7;

  // ----------------------------------------------------------------
  // lane width of the current phase
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SFPI_SINGLE = 2'b00,
    SFPI_DUAL   = 2'b01,
    SFPI_QUAD   = 2'b10
  } sfpi_mode_t;

  // ----------------------------------------------------------------
  // link state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SFPI_UNARMED = 2'b00,
    SFPI_DESEL   = 2'b01,
    SFPI_ACTIVE  = 2'b10,
    SFPI_PAUSED  = 2'b11
  } sfpi_state_t;

endpackage

// *** hw/sfpi_stream_if.sv ***
// sfpi_stream_if: byte stream with valid and ready
// assumes: one clock domain shared by source and sink
`timescale 1ns/1ps
`default_nettype none
interface sfpi_stream_if #(
  parameter int unsigned WIDTH = 8
);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// *** hw/sfpi_fifo.sv ***
// sfpi_fifo: synchronous fifo with a registered output stage
// assumes: same clock on both sides, synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module sfpi_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic  clock_i,
  input  wire logic  rst_n_i,
  sfpi_stream_if.snk wr,
  sfpi_stream_if.src rd
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp_q;
  logic [AW-1:0]    rp_q;
  logic [AW:0]      cnt_q;
  logic             ov_q;
  logic [WIDTH-1:0] od_q;

  // ----------------------------------------------------------------
  // pointers and flags
  // ----------------------------------------------------------------
  wire full   = (cnt_q == (AW+1)'(DEPTH));
  wire empty  = (cnt_q == '0);
  wire push   = wr.valid && !full;
  // the output register refills whenever it is free or being taken
  wire pop    = !empty && (!ov_q || rd.ready);

  assign wr.ready = !full;
  assign rd.valid = ov_q;
  assign rd.data  = od_q;

  always_ff @(posedge clock_i)
  begin
    if (push)
    begin
      mem[wp_q] <= wr.data;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
      ov_q  <= 1'b0;
      od_q  <= '0;
    end
    else
    begin
      if (push)
      begin
        wp_q <= wp_q + 1'b1;
      end
      if (pop)
      begin
        rp_q <= rp_q + 1'b1;
        od_q <= mem[rp_q];
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      ov_q  <= pop || (ov_q && !rd.ready);
    end
  end
endmodule
`default_nettype wire

// *** test/sfpi_core_props.sv ***
// sfpi_core_props: concurrent checks on the serial flash pin interface
// assumes: bound into sfpi_core, one clock, synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module sfpi_core_props (
  input wire logic       clock_i,
  input wire logic       rst_n_i,
  input wire logic       sck_i,
  input wire logic       cs_n_i,
  input wire logic [3:0] lane_i,
  input wire logic [3:0] lane_o,
  input wire logic [3:0] lane_oe_o,
  input wire logic       quad_cfg_i,
  input wire logic [1:0] mode_i,
  input wire logic       out_phase_i,
  input wire logic       busy_i,
  input wire logic [2:0] protect_range_bits_i,
  input wire logic       wr_req_i,
  input wire logic       wr_grant_o,
  input wire logic       wr_reject_o,
  input wire logic       standby_o,
  input wire logic       selected_o
);
  // ---
  // checks, margins cover the input synchronisers
  // ---
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_desel; cs_n_i [*5]; endsequence
  sequence s_pause; (!cs_n_i && !quad_cfg_i && !lane_i[3]) [*5]; endsequence
  sequence s_guard; (!lane_i[2] && !quad_cfg_i) [*4] ##0 wr_req_i; endsequence
  // leaving the output phase clears the lanes, so only a steady phase counts
  sequence s_held; (!cs_n_i && sck_i && out_phase_i) [*6]; endsequence
  property p_desel_float; s_desel |-> lane_oe_o == 4'h0 && !selected_o; endproperty
  a_desel_float: assert property (p_desel_float) else $error("lanes driven while deselected");
  property p_standby; (cs_n_i && !busy_i) [*5] |-> standby_o; endproperty
  a_standby: assert property (p_standby) else $error("standby missing");
  property p_busy_awake; busy_i [*3] |-> !standby_o; endproperty
  a_busy_awake: assert property (p_busy_awake) else $error("standby while busy");
  property p_pause_float; s_pause |-> lane_oe_o == 4'h0; endproperty
  a_pause_float: assert property (p_pause_float) else $error("lanes driven in pause");
  property p_guard_reject; s_guard ##0 protect_range_bits_i == 3'h7 |=> wr_reject_o && !wr_grant_o;
  endproperty
  a_guard_reject: assert property (p_guard_reject) else $error("guarded write granted");
  property p_open_grant; wr_req_i && protect_range_bits_i == 3'h0 |=> wr_grant_o && !wr_reject_o;
  endproperty
  a_open_grant: assert property (p_open_grant) else $error("open write rejected");
  property p_quad_open; quad_cfg_i [*4] ##0 wr_req_i |=> !wr_reject_o; endproperty
  a_quad_open: assert property (p_quad_open) else $error("reject in four-lane config");
  property p_out_still; s_held |-> $stable(lane_o); endproperty
  a_out_still: assert property (p_out_still) else $error("output moved without fall");
  property p_single_lane; (mode_i == 2'b00) [*3] ##0 lane_oe_o != 4'h0 |-> lane_oe_o == 4'h2;
  endproperty
  a_single_lane: assert property (p_single_lane) else $error("single lane enables");
  property p_dual_lanes; (mode_i == 2'b01) [*3] ##0 lane_oe_o != 4'h0 |-> lane_oe_o == 4'h3;
  endproperty
  a_dual_lanes: assert property (p_dual_lanes) else $error("dual lane enables");
  property p_quad_lanes; (mode_i == 2'b10) [*3] ##0 lane_oe_o != 4'h0 |-> lane_oe_o == 4'hf;
  endproperty
  a_quad_lanes: assert property (p_quad_lanes) else $error("quad lane enables");
endmodule
bind sfpi_core sfpi_core_props u_props (.clock_i, .rst_n_i, .sck_i, .cs_n_i, .lane_i, .lane_o,
  .lane_oe_o, .quad_cfg_i, .mode_i, .out_phase_i, .busy_i, .protect_range_bits_i, .wr_req_i,
  .wr_grant_o,
  .wr_reject_o, .standby_o, .selected_o);
`default_nettype wire

// *** test/sfpi_host.sv ***
// sfpi_host: behavioural bus master on the far side of the pins
// assumes: tasks called from the bench; sck half period 62.5 ns
`timescale 1ns/1ps
`default_nettype none
module sfpi_host (
  input  wire logic       clock_i,
  input  wire logic [3:0] dev_i,
  input  wire logic [3:0] dev_oe_i,
  output logic            sck_o,
  output logic            cs_n_o,
  output logic [3:0]      pin_o
);
  logic [3:0] hv;
  logic [3:0] hoe;
  logic [3:0] pk;
  logic       flt;
  initial
  begin
    {hv, hoe, pk} = 12'h000;
    flt = 1'b0;
    sck_o = 1'b0;
    cs_n_o = 1'b0;
  end
  // undriven lanes 0 and 1 wander so a stale bit never reads as valid; lanes 2 and 3 rest high
  always @(posedge clock_i) flt <= !flt;
  always_comb
    for (int k = 0; k < 4; k++)
      pin_o[k] = dev_oe_i[k] ? dev_i[k] : hoe[k] ? hv[k] : pk[k] ? 1'b0 : (k > 1) ? 1'b1 : flt;
  // new frame with the chosen idle clock level
  task automatic frame(input logic hi);
    cs_n_o = 1'b1;
    #250 sck_o = hi;
    #250 cs_n_o = 1'b0;
    #250;
  endtask
  task automatic desel();
    cs_n_o = 1'b1;
    #250;
  endtask
  // pause and protect are only parked while selected
  task automatic park(input int k, input logic on);
    pk[k] = on;
  endtask
  task automatic shift_in(input logic [7:0] b, input int w, input int n);
    for (int i = 0; i < n; i += w)
    begin
      hoe = 4'((1 << w) - 1);
      hv = 4'(b >> (8 - w));
      b = b << w;
      #62.5 sck_o = 1'b1;
      #62.5 sck_o = 1'b0;
    end
    hoe = 4'h0;
  endtask
  // sampled late in the high phase: the device holds until the next fall
  task automatic shift_out(input int w, output logic [7:0] b);
    b = 8'h00;
    for (int i = 0; i < 8; i += w)
    begin
      sck_o = 1'b0;
      #62.5 sck_o = 1'b1;
      #62.5 b = (b << w) | 8'(w == 1 ? {3'h0, pin_o[1]} : pin_o & 4'((1 << w) - 1));
    end
  endtask
endmodule
`default_nettype wire

// *** test/serial_flash_pin_interface_test.sv ***
// serial_flash_pin_interface_test: self-checking bench for sfpi_core
// assumes: sfpi_host as the bus master, default design parameters
`timescale 1ns/1ps
`default_nettype none
module serial_flash_pin_interface_test;
  logic        clock_i, rst_n_i, sck_i, cs_n_i, quad_cfg_i, out_phase_i, busy_i, tx_valid_i;
  logic        tx_ready_o, rx_valid_o, rx_ready_i, wr_req_i, wr_grant_o, wr_reject_o, want;
  logic        standby_o, selected_o, rx_overflow_o, tx_underrun_o, hold_rx;
  logic [3:0]  lane_i, lane_o, lane_oe_o;
  logic [1:0]  mode_i;
  logic [7:0]  tx_data_i, rx_data_o, b, got;
  logic [2:0]  protect_range_bits_i, code;
  logic [5:0]  wr_block_i;
  logic [31:0] seed = 32'hf43cf4d2;
  logic [7:0]  exp_q[$];
  int          bad_count = 0, checked = 0, spare = 0;
  sfpi_core dut (.clock_i, .rst_n_i, .sck_i, .cs_n_i, .lane_i, .lane_o, .lane_oe_o, .quad_cfg_i,
    .mode_i, .out_phase_i, .busy_i, .tx_data_i, .tx_valid_i, .tx_ready_o, .rx_data_o,
    .rx_valid_o, .rx_ready_i, .protect_range_bits_i, .wr_req_i, .wr_block_i, .wr_grant_o,
    .wr_reject_o, .standby_o, .selected_o, .rx_overflow_o, .tx_underrun_o);
  sfpi_host host (.clock_i, .dev_i(lane_o), .dev_oe_i(lane_oe_o), .sck_o(sck_i),
    .cs_n_o(cs_n_i), .pin_o(lane_i));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic results();
    $display("%0d compares, %0d wrong", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic load(input logic [7:0] d);
    int n = 0;
    tick(1);
    tx_data_i = d;
    tx_valid_i = 1'b1;
    while (tx_ready_o !== 1'b1 && n < 200)
    begin
      tick(1);
      n++;
    end
    tick(1);
    tx_valid_i = 1'b0;
  endtask
  initial
  begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  initial
  begin
    #500000 bad_count++;
    $display("watchdog expired");
    results();
  end
  // ---
  // receive monitor and sink stalls
  // ---
  always @(posedge clock_i)
  begin
    #1 rx_ready_i = !hold_rx && (rnd() % 3 != 0);
  end
  always @(posedge clock_i)
    if (rx_valid_o === 1'b1 && rx_ready_i === 1'b1)
    begin
      if (exp_q.size() > 0) chk("rx byte", exp_q.pop_front(), rx_data_o);
      else if (spare > 0) spare--;
      else chk("rx byte count", 8'h00, 8'h01);
    end
  // ---
  // scenarios
  // ---
  initial
  begin
    {rst_n_i, quad_cfg_i, out_phase_i, busy_i, tx_valid_i, rx_ready_i, wr_req_i, hold_rx} = '0;
    {mode_i, tx_data_i, protect_range_bits_i, wr_block_i} = '0;
    tick(16);
    rst_n_i = 1'b1;
    tick(4);
    host.shift_in(8'h5a, 1, 8);
    host.frame(1'b0);
    tick(1);
    chk("selected", 8'h01, selected_o);
    $display("test arming done");
    for (int w = 1; w <= 4; w = w * 2)
    begin
      tick(1);
      quad_cfg_i = (w == 4);
      mode_i = 2'(w >> 1);
      repeat (3)
      begin
        b = 8'(rnd());
        exp_q.push_back(b);
        host.shift_in(b, w, 8);
      end
    end
    tick(1);
    {quad_cfg_i, mode_i} = 3'h0;
    b = 8'(rnd());
    exp_q.push_back(b);
    host.shift_in(b, 1, 4);
    host.park(3, 1'b1);
    host.shift_in(8'hff, 1, 3);
    host.park(3, 1'b0);
    host.shift_in(b << 4, 1, 4);
    host.shift_in(8'(rnd()), 1, 5);
    host.frame(1'b1);
    $display("test write done");
    for (int w = 1; w <= 4; w = w * 2)
    begin
      tick(1);
      quad_cfg_i = (w == 4);
      mode_i = 2'(w >> 1);
      out_phase_i = 1'b1;
      repeat (2)
      begin
        b = 8'(rnd());
        load(b);
        host.shift_out(w, got);
        chk("read byte", b, got);
      end
      tick(1);
      out_phase_i = 1'b0;
      host.frame(1'b1);
    end
    tick(1);
    {quad_cfg_i, mode_i} = 3'h0;
    out_phase_i = 1'b1;
    host.shift_out(1, got);
    chk("underrun byte", 8'hff, got);
    chk("underrun flag", 8'h01, tx_underrun_o);
    tick(1);
    out_phase_i = 1'b0;
    host.frame(1'b0);
    $display("test read done");
    tick(1);
    for (int i = 0; i < 10; i++)
    begin
      code = (i < 8) ? 3'(i) : 3'h7;
      host.park(2, i != 9);
      quad_cfg_i = (i == 8);
      tick(5);
      protect_range_bits_i = code;
      wr_block_i = 6'(rnd());
      want = i < 8 && code != 3'h0 && int'(wr_block_i) >= 64 - (1 << (int'(code) - 1));
      wr_req_i = 1'b1;
      tick(1);
      wr_req_i = 1'b0;
      chk("reject", 8'(want), wr_reject_o);
      chk("grant", 8'(!want), wr_grant_o);
    end
    quad_cfg_i = 1'b0;
    $display("test protect done");
    host.desel();
    tick(1);
    busy_i = 1'b1;
    tick(6);
    chk("standby busy", 8'h00, standby_o);
    busy_i = 1'b0;
    tick(6);
    chk("standby", 8'h01, standby_o);
    chk("deselected", 8'h00, selected_o);
    $display("test standby done");
    host.frame(1'b0);
    tick(50);
    hold_rx = 1'b1;
    tick(2);
    for (int i = 0; i < 20; i++)
    begin
      b = 8'(rnd());
      if (i < 16) exp_q.push_back(b);
      host.shift_in(b, 1, 8);
      tick(10);
      if (i == 15) chk("overflow early", 8'h00, rx_overflow_o);
    end
    chk("overflow", 8'h01, rx_overflow_o);
    spare = 1;
    hold_rx = 1'b0;
    tick(300);
    chk("rx left", 8'h00, 8'(exp_q.size()));
    $display("test fifo done");
    results();
  end
endmodule
`default_nettype wire
